// ==== rtl/ms_tick_gen.sv ====
// Millisecond tick generator, restarted by a clear
`timescale 1ns/10ps
`default_nettype none
module ms_tick_gen (
   // Clock and reset
   input  wire logic clock,
   input  wire logic reset_n,
   // Control
   input  wire logic clear,
   output logic      tick
);
   localparam logic [residual_overvolt_pkg::PRE_W-1:0] LAST =
      residual_overvolt_pkg::PRE_W'(residual_overvolt_pkg::MS_CYCLES - 1);
   logic [residual_overvolt_pkg::PRE_W-1:0] count_ff;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         count_ff <= '0;
      end else if (clear || count_ff == LAST) begin
         count_ff <= '0;
      end else begin
         count_ff <= count_ff + 1'b1;
      end
   end

   assign tick = !clear && (count_ff == LAST);
endmodule
`default_nettype wire

// ==== rtl/residual_overvolt_function.sv ====
// Residual definite-time overvoltage start and trip logic
`timescale 1ns/10ps
`default_nettype none
module residual_overvolt_function (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        reset_n,
   // Measurement from upstream, percent of rated voltage
   input  wire logic [7:0]  residual_voltage_rms,
   // Settings
   input  wire logic [7:0]  start_voltage_setting,
   input  wire logic [15:0] trip_delay_setting,
   input  wire logic        operation_select,
   input  wire logic        start_only_option,
   // User blocking, asynchronous to the clock
   input  wire logic        block_input,
   // Results
   output logic             general_start_out,
   output logic             general_trip_out,
   output logic             internal_start,
   output logic             internal_trip
);
   // Characteristic state: bit 0 is the start and bit 1 the trip, so the
   // internal indications come straight from the state flip-flops
   typedef enum logic [1:0] {
      CHAR_IDLE    = 2'b00,
      CHAR_TIMING  = 2'b01,
      CHAR_EXPIRED = 2'b11
   } char_state_t;

   // Block synchroniser
   logic                                      blk_meta_ff;
   logic                                      blk_sync_ff;

   // Settings after clamping
   logic [residual_overvolt_pkg::VOLT_W-1:0]  level;
   logic [residual_overvolt_pkg::DELAY_W-1:0] delay_lim;

   // Start condition
   logic                                      enabled;
   logic                                      blocked;
   logic                                      active;
   logic                                      over;
   logic                                      run;

   // Definite delay timer
   logic                                      tick_clear;
   logic                                      ms_tick;
   logic                                      timer_full;
   logic                                      expired;
   logic [residual_overvolt_pkg::DELAY_W-1:0] elapsed_ff;
   logic [residual_overvolt_pkg::DELAY_W-1:0] nxt_elapsed;

   // Characteristic and decision logic
   char_state_t                               state_ff;
   char_state_t                               nxt_state;
   logic                                      trip_allowed;
   logic                                      nxt_gen_start;
   logic                                      nxt_gen_trip;
   logic                                      gen_start_ff;
   logic                                      gen_trip_ff;

   // Block comes from user logic that may be on another clock; only the
   // second stage is read, so a block acts two edges late
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         blk_meta_ff <= 1'b0;
         blk_sync_ff <= 1'b0;
      end else begin
         blk_meta_ff <= block_input;
         blk_sync_ff <= blk_meta_ff;
      end
   end

   // Out-of-range settings are clamped rather than refused, so a bad
   // setting word can never switch the protection off
   always_comb begin
      level = start_voltage_setting;
      if (start_voltage_setting < residual_overvolt_pkg::START_MIN) begin
         level = residual_overvolt_pkg::START_MIN;
      end else if (start_voltage_setting > residual_overvolt_pkg::START_MAX) begin
         level = residual_overvolt_pkg::START_MAX;
      end
   end

   // A delay above the top of the range is held at the top
   always_comb begin
      delay_lim = trip_delay_setting;
      if (trip_delay_setting > residual_overvolt_pkg::DELAY_MAX) begin
         delay_lim = residual_overvolt_pkg::DELAY_MAX;
      end
   end

   // Start condition
   assign enabled = operation_select == residual_overvolt_pkg::OPER_ON;
   assign blocked = blk_sync_ff;
   assign active  = enabled && !blocked;
   // Strictly above: a value equal to the setting does not start
   assign over    = residual_voltage_rms > level;
   assign run     = active && over;

   // The prescaler restarts at each start, so the first millisecond is
   // whole; the cost is that a short dip restarts the full delay
   assign tick_clear = !run;

   ms_tick_gen u_ms_tick (
      .clock   (clock),
      .reset_n (reset_n),
      .clear   (tick_clear),
      .tick    (ms_tick)
   );

   // A zero delay is full at once, so start and trip rise together
   assign timer_full = elapsed_ff >= delay_lim;

   // Whole milliseconds since the start; holds at the limit, never wraps
   always_comb begin
      nxt_elapsed = elapsed_ff;
      if (!run) begin
         nxt_elapsed = '0;
      end else if (ms_tick && !timer_full) begin
         nxt_elapsed = elapsed_ff + 1'b1;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         elapsed_ff <= '0;
      end else begin
         elapsed_ff <= nxt_elapsed;
      end
   end

   // Fixed delay: the excess over the setting plays no part
   assign expired = run && timer_full;

   // Characteristic: idle, timing toward a trip, or expired
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         CHAR_IDLE: begin
            if (expired) begin
               nxt_state = CHAR_EXPIRED;
            end else if (run) begin
               nxt_state = CHAR_TIMING;
            end else begin
               nxt_state = CHAR_IDLE;
            end
         end
         CHAR_TIMING: begin
            if (!run) begin
               nxt_state = CHAR_IDLE;
            end else if (expired) begin
               nxt_state = CHAR_EXPIRED;
            end else begin
               nxt_state = CHAR_TIMING;
            end
         end
         CHAR_EXPIRED: begin
            if (!run) begin
               nxt_state = CHAR_IDLE;
            end else if (!expired) begin
               // Delay raised above the elapsed time while tripped
               nxt_state = CHAR_TIMING;
            end else begin
               nxt_state = CHAR_EXPIRED;
            end
         end
         default: begin
            // The spare code is never entered; leave it at once
            nxt_state = CHAR_IDLE;
         end
      endcase
   end

   // Reset leaves the function idle with no start or trip
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= CHAR_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Decision logic: the trip is gated after the characteristic, so the
   // internal trip still shows an expired delay in start-only mode
   assign trip_allowed = !start_only_option;

   always_comb begin
      nxt_gen_start = 1'b0;
      nxt_gen_trip  = 1'b0;
      if (nxt_state != CHAR_IDLE) begin
         nxt_gen_start = 1'b1;
      end
      if (nxt_state == CHAR_EXPIRED && trip_allowed) begin
         nxt_gen_trip = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         gen_start_ff <= 1'b0;
      end else begin
         gen_start_ff <= nxt_gen_start;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         gen_trip_ff <= 1'b0;
      end else begin
         gen_trip_ff <= nxt_gen_trip;
      end
   end

   // All four outputs come straight from flip-flops
   assign internal_start    = state_ff[0];
   assign internal_trip     = state_ff[1];
   assign general_start_out = gen_start_ff;
   assign general_trip_out  = gen_trip_ff;
endmodule
`default_nettype wire

// ==== rtl/residual_overvolt_pkg.sv ====
// Constants of the residual definite-time overvoltage function
// Summary of operation
// - Compare residual RMS against percent start setting
// - Above setting: assert start, run delay
// - Fixed millisecond delay, independent of excess
// - Operation Off suppresses start and trip
// - Block input disables whole function
// - Start-only option suppresses general trip output
// - Decision logic drives general start, trip
// - Start-only zero gives both; one no trip
package residual_overvolt_pkg;
   localparam int          VOLT_W        = 8;
   localparam int          DELAY_W       = 16;
   localparam logic [7:0]  START_MIN     = 8'h02;
   localparam logic [7:0]  START_MAX     = 8'h3C;
   localparam logic [7:0]  START_DEFAULT = 8'h1E;
   localparam logic [15:0] DELAY_MAX     = 16'hEA60;
   localparam logic [15:0] DELAY_DEFAULT = 16'h0064;
   localparam int          MS_NS         = 1000000;
   localparam int          CLK_NS        = 10;
   localparam int          MS_CYCLES     = MS_NS / CLK_NS;
   localparam int          PRE_W         = 17;
   typedef enum logic [0:0] {
      OPER_OFF = 1'b0,
      OPER_ON  = 1'b1
   } oper_t;
   localparam oper_t OPER_DEFAULT = OPER_ON;
   localparam logic  START_ONLY_DEFAULT = 1'b0;
endpackage

// ==== tb/overvolt_monitor.sv ====
// Assertion checker for the residual overvoltage function
`timescale 1ns/10ps
`default_nettype none
module overvolt_monitor (
   // Clock and reset
   input wire logic        clock,
   input wire logic        reset_n,
   // Inputs
   input wire logic [7:0]  residual_voltage_rms,
   input wire logic [7:0]  start_voltage_setting,
   input wire logic [15:0] trip_delay_setting,
   input wire logic        operation_select,
   input wire logic        start_only_option,
   input wire logic        block_input,
   // Results
   input wire logic        general_start_out,
   input wire logic        general_trip_out,
   input wire logic        internal_start,
   input wire logic        internal_trip
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   a_trip_needs_start: assert property (general_trip_out |-> general_start_out)
      else $error("trip without start");
   a_trip_from_internal: assert property (general_trip_out |-> internal_trip)
      else $error("trip without cause");
   a_start_only_quiet: assert property (start_only_option[*2] |-> !general_trip_out)
      else $error("trip in start only");
   a_off_quiet: assert property (!operation_select[*2] |-> !internal_start)
      else $error("start while off");
   a_block_quiet: assert property (block_input[*4] |-> !general_start_out)
      else $error("start while blocked");
   // Only settings up to the top of the range, since higher ones are clamped down
   a_low_quiet: assert property ((residual_voltage_rms <= start_voltage_setting
      && start_voltage_setting < 8'h3D)[*2] |-> !internal_start) else $error("start at low level");
   a_zero_delay: assert property ($rose(internal_start)
      && trip_delay_setting == 16'h0000 |-> internal_trip) else $error("zero delay late");
   a_delay_holds: assert property ($rose(internal_start)
      && trip_delay_setting != 16'h0000 |-> !internal_trip[*8]) else $error("trip too early");
endmodule
bind residual_overvolt_function overvolt_monitor mon_u (
   .clock                 (clock),
   .reset_n               (reset_n),
   .residual_voltage_rms  (residual_voltage_rms),
   .start_voltage_setting (start_voltage_setting),
   .trip_delay_setting    (trip_delay_setting),
   .operation_select      (operation_select),
   .start_only_option     (start_only_option),
   .block_input           (block_input),
   .general_start_out     (general_start_out),
   .general_trip_out      (general_trip_out),
   .internal_start        (internal_start),
   .internal_trip         (internal_trip)
);
`default_nettype wire

// ==== tb/rms_source.sv ====
// Upstream model delivering residual RMS values
`timescale 1ns/10ps
`default_nettype none
module rms_source (
   input wire logic       clock,
   input wire logic [7:0] level,
   output var logic [7:0] rms
);
   initial rms = 8'h00;
   always @(posedge clock) rms <= #1 level;
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Testbench for the residual overvoltage function
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic clock = 1'b0, reset_n = 1'b0, oper = 1'b1, st_only = 1'b0, blk = 1'b0;
   logic [7:0] level = 8'h00, rms, setting = 8'h1E;
   logic [15:0] delay = 16'h0000;
   logic gs, gt, ist, itr;
   int n_fail = 0, n_compared = 0, k;
   always #5 clock = ~clock;
   rms_source src_u (.clock(clock), .level(level), .rms(rms));
   residual_overvolt_function dut_u (.clock(clock), .reset_n(reset_n),
      .residual_voltage_rms(rms), .start_voltage_setting(setting),
      .trip_delay_setting(delay), .operation_select(oper), .start_only_option(st_only),
      .block_input(blk), .general_start_out(gs), .general_trip_out(gt),
      .internal_start(ist), .internal_trip(itr));
   task automatic chk(input logic s, t, string m);
      n_compared++;
      if (gs !== s || gt !== t || ist !== s) begin
         n_fail++;
         $display("Error %0t: %s start %b trip %b", $time, m, gs, gt);
      end
   endtask
   // Six cycles cover delivery, block sync and the output register
   task automatic go(input logic [7:0] v, input logic s, t, string m);
      level = v;
      repeat (6) @(posedge clock);
      #2 chk(s, t, m);
   endtask
   task automatic summarize;
      $display("Compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clock);
      #2 reset_n = 1'b1;
      chk(1'b0, 1'b0, "reset");
      for (k = 0; k < 3; k++) begin
         setting = k == 0 ? 8'h02 : k == 1 ? 8'h3C : 8'h1E;
         go(setting, 1'b0, 1'b0, "at level");
         go(setting + 8'h01, 1'b1, 1'b1, "above");
      end
      // Settings outside the range are clamped to its ends
      setting = 8'h00;
      go(8'h02, 1'b0, 1'b0, "clamp low");
      go(8'h03, 1'b1, 1'b1, "clamp low above");
      setting = 8'hFF;
      go(8'h3C, 1'b0, 1'b0, "clamp high");
      go(8'h3D, 1'b1, 1'b1, "clamp high above");
      $display("Levels test done");
      setting = 8'h1E;
      st_only = 1'b1;
      go(8'h1F, 1'b1, 1'b0, "start only");
      n_compared++;
      if (itr !== 1'b1) begin
         n_fail++;
         $display("Error %0t: internal trip masked", $time);
      end
      st_only = 1'b0;
      oper = 1'b0;
      go(8'h1F, 1'b0, 1'b0, "off");
      oper = 1'b1;
      blk = 1'b1;
      go(8'h1F, 1'b0, 1'b0, "blocked");
      blk = 1'b0;
      go(8'h1F, 1'b1, 1'b1, "free");
      go(8'h10, 1'b0, 1'b0, "drop");
      $display("Gates test done");
      // Only 1 ms is timed, longer delays would swamp the run
      delay = 16'h0001;
      go(8'h28, 1'b1, 1'b0, "timing");
      k = 0;
      while (gt !== 1'b1 && k < 100010) begin
         @(posedge clock);
         #2 k++;
      end
      n_compared++;
      // Trip lands 1 ms and one edge after the rms edge, five edges before the loop
      if (k != residual_overvolt_pkg::MS_CYCLES - 4) begin
         n_fail++;
         $display("Error %0t: trip after %0d", $time, k);
      end
      $display("Delay test done");
      summarize();
   end
endmodule
`default_nettype wire
